// ### logic/aswt_pkg.sv
package aswt_pkg;
	// clock rate
	localparam int CLK_HZ            = 100_000_000;
	localparam int CLK_NS            = 10;
	// documented times, in their own units
	localparam int TON_MS            = 5;
	localparam int CMD_OPEN_MS       = 16;
	localparam int CMD_CLOSE_MS      = 26;
	localparam int START_US          = 5;
	localparam int STOP_US           = 5;
	localparam int BIT_MIN_US        = 10;
	localparam int BIT_MAX_US        = 100;
	localparam int TIMEOUT_US        = 220;
	localparam int SLV_TKO_MIN_US    = 1;
	localparam int SLV_TKO_MAX_US    = 5;
	// derived cycle counts
	localparam int TON_CYC           = TON_MS * (CLK_HZ / 1000);
	localparam int CMD_OPEN_CYC      = CMD_OPEN_MS * (CLK_HZ / 1000);
	localparam int CMD_CLOSE_CYC     = CMD_CLOSE_MS * (CLK_HZ / 1000);
	localparam int START_CYC         = (START_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int STOP_CYC          = (STOP_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int BIT_MIN_CYC       = (BIT_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int BIT_MAX_CYC       = (BIT_MAX_US * 1000) / CLK_NS;
	localparam int TIMEOUT_CYC       = (TIMEOUT_US * 1000) / CLK_NS;
	localparam int SLV_TKO_CYC       = (((SLV_TKO_MIN_US + SLV_TKO_MAX_US) / 2) * 1000) / CLK_NS;
	// receive states
	typedef enum logic [3:0] {
		ASWT_IDLE  = 4'b0001,
		ASWT_ARMED = 4'b0010,
		ASWT_BIT   = 4'b0100,
		ASWT_TKO   = 4'b1000
	} aswt_state_e;
endpackage

// ### logic/aswt_link.sv
`timescale 1ns/100ps
module aswt_link
	import aswt_pkg::*;
#(
	parameter int TON_CYCLES       = TON_CYC,
	parameter int CMD_OPEN_CYCLES  = CMD_OPEN_CYC,
	parameter int CMD_CLOSE_CYCLES = CMD_CLOSE_CYC,
	parameter int TIMEOUT_CYCLES   = TIMEOUT_CYC
) (
	// clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_nrst,
	// data pin
	input  wire logic i_data,
	output logic      o_data,
	output logic      o_data_oe_n,
	// takeover request from command layer
	input  wire logic i_slv_tko,
	// received bits
	output logic      o_bit_valid,
	output logic      o_bit_value,
	output logic      o_frame_start,
	output logic      o_timeout,
	output logic      o_bit_error,
	// status
	output logic      o_result_valid,
	output logic      o_cmd_window
);
	// accepted bit period window, widened by the 0.8..1.2 tolerance
	localparam int PER_LO  = (BIT_MIN_CYC * 8) / 10;
	localparam int PER_HI  = (BIT_MAX_CYC * 12) / 10;
	// a high phase longer than the widest period can only be a stop
	localparam int STOP_HI = PER_HI;
	// counter widths
	localparam int PW      = $clog2(CMD_CLOSE_CYCLES + 2);
	localparam int BW      = $clog2(TIMEOUT_CYCLES + 2);

	// refuse settings the counters cannot serve: the time-out must outlast
	// the widest period, and the time base must reach every mark
	if (TIMEOUT_CYCLES <= PER_HI || CMD_OPEN_CYCLES >= CMD_CLOSE_CYCLES
			|| TON_CYCLES < 1 || TON_CYCLES > CMD_CLOSE_CYCLES) begin : g_bad_timing
		$error("aswt_link: bad timing parameters");
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	logic              d_meta;
	logic              d_sync;
	logic              d_prev;
	logic [PW-1:0]     por_cnt;
	logic [BW-1:0]     low_cnt;
	logic [BW-1:0]     high_cnt;
	logic [BW-1:0]     per_cnt;
	logic [BW-1:0]     hi_time;
	logic [BW-1:0]     edge_gap;
	logic [BW-1:0]     tko_cnt;
	aswt_state_e       state;
	logic              rise;
	logic              fall;

	// edges of the synchronised pin, two cycles behind the pin itself
	assign rise = d_sync & ~d_prev;
	assign fall = ~d_sync & d_prev;

	// two-flop pin synchroniser
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			d_meta <= 1'b1;
			d_sync <= 1'b1;
			d_prev <= 1'b1;
		end else begin
			d_meta <= i_data;
			d_sync <= d_meta;
			d_prev <= d_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// power-on time base
	// counts to one past the window end, then holds so the flags stay put
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst)
			por_cnt <= '0;
		else if (por_cnt <= PW'(CMD_CLOSE_CYCLES))
			por_cnt <= por_cnt + PW'(1);
	end

	// result ready and entry window flags
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_result_valid <= 1'b0;
			o_cmd_window   <= 1'b0;
		end else begin
			o_result_valid <= (por_cnt >= PW'(TON_CYCLES - 1));
			o_cmd_window   <= (por_cnt >= PW'(CMD_OPEN_CYCLES))
				&& (por_cnt < PW'(CMD_CLOSE_CYCLES));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// level duration counters, saturating
	// low_cnt qualifies a start, high_cnt a stop, edge_gap the time-out
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			low_cnt  <= '0;
			high_cnt <= '0;
			edge_gap <= '0;
		end else begin
			low_cnt  <= d_sync ? '0 : (low_cnt == '1 ? low_cnt : low_cnt + BW'(1));
			high_cnt <= !d_sync ? '0 : (high_cnt == '1 ? high_cnt : high_cnt + BW'(1));
			edge_gap <= rise ? '0 : (edge_gap == '1 ? edge_gap : edge_gap + BW'(1));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive state machine
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state         <= ASWT_IDLE;
			per_cnt       <= '0;
			hi_time       <= '0;
			tko_cnt       <= '0;
			o_bit_valid   <= 1'b0;
			o_bit_value   <= 1'b0;
			o_frame_start <= 1'b0;
			o_timeout     <= 1'b0;
			o_bit_error   <= 1'b0;
		end else begin
			// pulses default low, raised for one cycle below
			o_bit_valid   <= 1'b0;
			o_frame_start <= 1'b0;
			o_timeout     <= 1'b0;
			o_bit_error   <= 1'b0;
			// no rising edge for too long: drop the frame, in any state but ASWT_IDLE
			if (state != ASWT_IDLE && edge_gap >= BW'(TIMEOUT_CYCLES - 1)) begin
				state     <= ASWT_IDLE;
				o_timeout <= 1'b1;
			end else begin
				case (state)
					ASWT_IDLE: begin
						// start: long low then rising edge
						if (rise && low_cnt >= BW'(START_CYC)) begin
							state         <= ASWT_ARMED;
							o_frame_start <= 1'b1;
						end
					end
					ASWT_ARMED: begin
						// first bit begins at next rising edge
						// the start pulse itself is never decoded as a bit
						if (rise) begin
							state   <= ASWT_BIT;
							per_cnt <= '0;
						end
					end
					ASWT_BIT: begin
						// count the period; the fall marks the end of the high pulse
						per_cnt <= per_cnt + BW'(1);
						if (fall)
							hi_time <= per_cnt;
						if (rise) begin
							per_cnt <= '0;
							// window widened by 0.8..1.2 tolerance
							if (per_cnt < BW'(PER_LO) || per_cnt > BW'(PER_HI))
								o_bit_error <= 1'b1;
							else begin
								o_bit_valid <= 1'b1;
								o_bit_value <= (hi_time > (per_cnt >> 1));
							end
						end
						// stop: high for longer than any legal bit period; a one bit
						// at the shortest period is already high longer than the
						// minimum stop time, so that time alone cannot end a frame
						if (d_sync && high_cnt > BW'(STOP_HI))
							state <= ASWT_IDLE;
						// takeover from the command layer wins over a stop
						if (i_slv_tko) begin
							state   <= ASWT_TKO;
							tko_cnt <= '0;
						end
					end
					// hold the line low for the takeover, then resume bit timing
					ASWT_TKO: begin
						tko_cnt <= tko_cnt + BW'(1);
						if (tko_cnt >= BW'(SLV_TKO_CYC - 1)) begin
							state   <= ASWT_BIT;
							per_cnt <= '0;
						end
					end
					default: state <= ASWT_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drive: low during slave takeover only (oe_n low = driving)
	// the value is low from the first clock after reset; only the enable moves, so no high is ever driven
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_data      <= 1'b1;
			o_data_oe_n <= 1'b1;
		end else begin
			o_data      <= 1'b0;
			o_data_oe_n <= !(state == ASWT_TKO);
		end
	end
endmodule

// ### dv/aswt_checker.sv
`timescale 1ns/100ps
module aswt_checker #(
	parameter int TON_CYCLES     = 50,
	parameter int TIMEOUT_CYCLES = 22000
) (
	input wire logic i_core_clk, i_nrst, i_data, i_slv_tko,
	input wire logic o_data, o_data_oe_n, o_bit_valid, o_bit_value,
	input wire logic o_frame_start, o_timeout, o_bit_error, o_result_valid, o_cmd_window
);
	int q;
	int l;
	int up;
	// cycles since reset release, saturating at the turn-on limit
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) up <= 0;
		else if (up < TON_CYCLES) up <= up + 1;
	end
	// cycles since the last line rise
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) q <= 0;
		else q <= $rose(i_data) ? 0 : q + 1;
	end
	// length of the current takeover low
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) l <= 0;
		else l <= o_data_oe_n ? 0 : l + 1;
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	sequence tko_s; $fell(o_data_oe_n) ##0 !o_data; endsequence
	result_up_a: assert property ((up >= TON_CYCLES) |-> o_result_valid)
		else $error("result flag late");
	result_hold_a: assert property (o_result_valid |=> o_result_valid)
		else $error("result flag dropped");
	timeout_gap_a: assert property (o_timeout |-> q >= TIMEOUT_CYCLES)
		else $error("timeout too early");
	bit_pulse_a: assert property (o_bit_valid |=> !o_bit_valid)
		else $error("bit pulse too long");
	bit_clean_a: assert property (o_bit_valid |-> !o_bit_error && i_data && q <= 8)
		else $error("bit not at a rise");
	frame_rise_a: assert property (o_frame_start |-> q <= 8 && !o_bit_valid)
		else $error("frame start not at a rise");
	tko_hold_a: assert property (tko_s |=> !o_data_oe_n [*8])
		else $error("takeover low too short");
	tko_max_a: assert property (l <= 500)
		else $error("takeover low too long");
	tko_min_a: assert property ($rose(o_data_oe_n) |-> $past(l) >= 100)
		else $error("takeover ended early");
	drive_low_a: assert property (!o_data_oe_n |-> !o_data)
		else $error("drive not low");
endmodule
bind aswt_link aswt_checker #(
	.TON_CYCLES    (TON_CYCLES),
	.TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) i_chk (
	.i_core_clk    (i_core_clk),
	.i_nrst        (i_nrst),
	.i_data        (i_data),
	.i_slv_tko     (i_slv_tko),
	.o_data        (o_data),
	.o_data_oe_n   (o_data_oe_n),
	.o_bit_valid   (o_bit_valid),
	.o_bit_value   (o_bit_value),
	.o_frame_start (o_frame_start),
	.o_timeout     (o_timeout),
	.o_bit_error   (o_bit_error),
	.o_result_valid(o_result_valid),
	.o_cmd_window  (o_cmd_window)
);

// ### dv/aswt_master.sv
`timescale 1ns/100ps
module aswt_master #(
	parameter int PUMP_CYC = 100, // charge-pump wait, scaled like the bench time base
	parameter int PROG_CYC = 200  // programming wait, scaled likewise
) (
	input  wire logic i_core_clk,
	output logic      o_line
);
	initial o_line = 1'b1;
	// hold a level for n cycles
	task automatic hold(input logic v, input int n);
		o_line = v;
		repeat (n) @(negedge i_core_clk);
	endtask
	// long low, then rise opens the frame
	task automatic start();
		hold(1'b0, 600);
		hold(1'b1, 250);
		hold(1'b0, 250);
	endtask
	// high pulse first, long for one
	task automatic send(input logic b, input int t);
		hold(1'b1, b ? t * 3 / 4 : t / 4);
		hold(1'b0, b ? t - t * 3 / 4 : t - t / 4);
	endtask
	// high past the widest legal period, which the far end reads as stop
	task automatic stop();
		hold(1'b1, 12100);
	endtask
	// idle high while the charge pump starts, before any write data
	task automatic pump_wait();
		hold(1'b1, PUMP_CYC);
	endtask
	// idle high while one address programs, before the next access
	task automatic prog_wait();
		hold(1'b1, PROG_CYC);
	endtask
endmodule

// ### dv/aswt_link_tb_top.sv
`timescale 1ns/100ps
module aswt_link_tb_top;
	logic clk, nrst, tko, m_line, pin, dd, doe, bv, bval, fs, tmo, berr, rv, cw;
	int err_count, compares, cyc, n_fs, n_tmo, n_err;
	logic q[$];
	assign pin = doe ? m_line : dd;
	aswt_link #(.TON_CYCLES(50), .CMD_OPEN_CYCLES(100), .CMD_CLOSE_CYCLES(200)) i_dut (
		.i_core_clk(clk), .i_nrst(nrst), .i_data(pin), .o_data(dd), .o_data_oe_n(doe),
		.i_slv_tko(tko), .o_bit_valid(bv), .o_bit_value(bval), .o_frame_start(fs),
		.o_timeout(tmo), .o_bit_error(berr), .o_result_valid(rv), .o_cmd_window(cw));
	aswt_master i_mst (.i_core_clk(clk), .o_line(m_line));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// watch pulses and bound the run
	always @(negedge clk) begin
		cyc++;
		if (bv) q.push_back(bval);
		if (fs) n_fs++;
		if (tmo) n_tmo++;
		if (berr) n_err++;
		if (cyc == 90000) begin
			err_count++;
			close_out();
		end
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s exp %0h got %0h", s, e, g);
		end
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic t_bits();
		i_mst.pump_wait();
		i_mst.start();
		i_mst.send(1, 1000);
		i_mst.send(0, 10000);
		i_mst.send(1, 1000);
		i_mst.send(0, 850);
		i_mst.stop();
		chk("bits", 3'b101, {q[0], q[1], q[2]});
		chk("bit errors", 0, n_err);
		chk("bit count", 4, q.size());
		i_mst.prog_wait();
		$display("bits done");
	endtask
	task automatic t_err();
		i_mst.start();
		i_mst.send(1, 700);
		i_mst.send(1, 1000);
		i_mst.stop();
		chk("short period", 1, n_err > 0);
		$display("error done");
	endtask
	task automatic t_tmo();
		n_fs = 0;
		i_mst.start();
		i_mst.send(1, 1000);
		i_mst.hold(0, 22100);
		chk("timeout", 1, n_tmo);
		i_mst.start();
		chk("restart", 2, n_fs);
		$display("timeout done");
	endtask
	task automatic t_tko();
		i_mst.hold(1, 100);
		tko = 1;
		@(negedge clk);
		tko = 0;
		repeat (5) @(negedge clk);
		chk("takeover", 0, {doe, pin});
		repeat (400) @(negedge clk);
		chk("released", 1, doe);
		i_mst.stop();
		$display("takeover done");
	endtask
	initial begin
		nrst = 0;
		tko = 0;
		repeat (12) @(negedge clk);
		nrst = 1;
		repeat (52) @(negedge clk);
		chk("result", 1, rv);
		chk("window early", 0, cw);
		repeat (100) @(negedge clk);
		chk("window", 1, cw);
		repeat (60) @(negedge clk);
		chk("window late", 0, cw);
		$display("power done");
		t_bits();
		t_err();
		t_tmo();
		t_tko();
		close_out();
	end
endmodule
